//--- logic/fpev_pkg.sv
// constants, types and register map of the flash program/erase/verify controller
//
// Notes on behaviour
// - leaving program mode: clear program bit, wait alpha, then clear program setup
// - dummy write of ff at least gamma after verify entry, read at least epsilon later
// - compare, compute reprogram data, leave verify after 32 bytes, wait eta, decide
// - program/verify loop repeats at most n times on the same bits
// - two 32-byte buffers: original data and reprogram data
// - erase block bit is set at least x after the software write enable bit
// - only one erase block bit at a time, blocks erased one after another
// - arm watchdog, set erase setup, set erase bit at least y later
// - erase bit held set no longer than z milliseconds
// - leaving erase mode: clear erase bit, wait alpha, then clear erase setup
// - erase-verify bit enters erase-verify; all-ones data moves to next address
// - erase/erase-verify loop repeats at most n times
// - reset pin low at least 20 clocks, at power-on at least 20 ms
package fpev_pkg;

  // ****************************************************************
  // clock and times
  // ****************************************************************
  localparam int unsigned CLK_PS      = 4000;
  localparam int unsigned T_X_US      = 1;
  localparam int unsigned T_Y_US      = 50;
  localparam int unsigned T_ZP_US     = 200;
  localparam int unsigned T_ZE_MS     = 10;
  localparam int unsigned T_ALPHA_US  = 10;
  localparam int unsigned T_GAMMA_US  = 20;
  localparam int unsigned T_EPS_US    = 2;
  localparam int unsigned T_ETA_US    = 5;
  localparam int unsigned T_POR_MS    = 20;
  localparam int unsigned RST_MIN_CLK = 20;
  localparam int unsigned N_MAX_DEF   = 1000;
  localparam logic [15:0] WDT_VAL_DEF = 16'h00ff;

  // ****************************************************************
  // device side
  // ****************************************************************
  localparam logic [1:0] DSEL_CTL   = 2'h0;
  localparam logic [1:0] DSEL_BLK   = 2'h1;
  localparam logic [1:0] DSEL_ARRAY = 2'h2;
  localparam logic [1:0] DSEL_WDT   = 2'h3;
  localparam int unsigned B_PROG = 0;
  localparam int unsigned B_ERASE = 1;
  localparam int unsigned B_PVER = 2;
  localparam int unsigned B_EVER = 3;
  localparam int unsigned B_PSU = 4;
  localparam int unsigned B_ESU = 5;
  localparam int unsigned B_SWE = 6;
  localparam logic [15:0] DUMMY_DATA  = 16'h00ff;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam int unsigned PROG_BYTES = 32;
  localparam int unsigned VER_WORDS  = 16;

  // ****************************************************************
  // own registers, byte offsets on the bus
  // ****************************************************************
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ADDR   = 8'h08;
  localparam logic [7:0] OFS_BLOCK  = 8'h0c;
  localparam logic [7:0] OFS_LEN    = 8'h10;
  localparam logic [7:0] OFS_PBUF   = 8'h40;
  localparam logic [7:0] OFS_RBUF   = 8'h60;
  localparam int unsigned C_ERASE = 0;
  localparam int unsigned C_PROG  = 1;
  localparam int unsigned C_RST   = 2;
  localparam int unsigned C_WEN   = 3;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        byte_acc;
    logic [1:0]  sel;
    logic [23:0] addr;
    logic [15:0] wdata;
  } fpev_dev_req_s;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SWE, ST_LOAD, ST_WDT, ST_SETUP, ST_PULSE, ST_PULSE_OFF,
    ST_SETUP_OFF, ST_VER_ON, ST_DUMMY, ST_READ, ST_VER_OFF, ST_FINISH
  } fpev_state_e;

endpackage

//--- logic/fpev_host.sv
// host controller that drives flash program, erase and verify sequences
`timescale 1ns/1ps
module fpev_host
  import fpev_pkg::*;
#(
  parameter int unsigned N_MAX     = N_MAX_DEF,
  parameter logic [15:0] WDT_VAL   = WDT_VAL_DEF,
  parameter int unsigned X_CYC     = (T_X_US * 1000000 + CLK_PS - 1) / CLK_PS,
  parameter int unsigned Y_CYC     = (T_Y_US * 1000000 + CLK_PS - 1) / CLK_PS,
  parameter int unsigned ZP_CYC    = (T_ZP_US * 1000000) / CLK_PS,
  parameter int unsigned ZE_CYC    = (T_ZE_MS * 1000000) / CLK_PS * 1000,
  parameter int unsigned ALPHA_CYC = (T_ALPHA_US * 1000000 + CLK_PS - 1) / CLK_PS,
  parameter int unsigned GAMMA_CYC = (T_GAMMA_US * 1000000 + CLK_PS - 1) / CLK_PS,
  parameter int unsigned EPS_CYC   = (T_EPS_US * 1000000 + CLK_PS - 1) / CLK_PS,
  parameter int unsigned ETA_CYC   = (T_ETA_US * 1000000 + CLK_PS - 1) / CLK_PS,
  parameter int unsigned POR_CYC   = (T_POR_MS * 1000000) / CLK_PS * 1000
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic [31:0]        hrdata,
  output logic               hresp,
  output fpev_dev_req_s      dev_req,
  input  wire logic [15:0]   dev_rdata,
  input  wire logic          dev_rvalid,
  input  wire logic          flash_error_flag,
  output logic               flash_write_enable_pin,
  output logic               reset_pin_n
);

  if (N_MAX < 1 || N_MAX > 65535 || POR_CYC < RST_MIN_CLK) begin : g_bad_param
    $error("fpev_host: retry limit or reset length out of range");
  end

  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic [31:0] prog_buf [8];
  logic [31:0] rep_buf [8];
  logic [23:0] base_addr;
  logic [2:0]  blk_sel;
  logic [15:0] ver_len;
  logic        wen;
  logic        wr_pend;
  logic [7:0]  wr_ofs;
  logic        busy;
  logic        done;
  logic        fail;
  logic        err_q;
  logic [15:0] tries;
  fpev_state_e state;

  wire        addr_ok   = hsel & hready & htrans[1];
  wire [7:0]  a_ofs     = {haddr[7:2], 2'b00};
  wire        in_pbuf   = (a_ofs[7:5] == OFS_PBUF[7:5]);
  wire        in_rbuf   = (a_ofs[7:5] == OFS_RBUF[7:5]);
  wire        wr_cmd    = wr_pend & (wr_ofs == OFS_CMD);
  wire [31:0] status_w  = {tries, 12'h000, err_q, fail, done, busy};
  wire [31:0] rd_mux    = (a_ofs == OFS_STATUS) ? status_w :
                          (a_ofs == OFS_CMD)    ? {28'h0000000, wen, 3'h0} :
                          (a_ofs == OFS_ADDR)   ? {8'h00, base_addr} :
                          (a_ofs == OFS_BLOCK)  ? {29'h0000000, blk_sel} :
                          (a_ofs == OFS_LEN)    ? {16'h0000, ver_len} :
                          in_pbuf               ? prog_buf[a_ofs[4:2]] :
                          in_rbuf               ? rep_buf[a_ofs[4:2]] : 32'h00000000;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_ofs  <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      wr_pend <= addr_ok & hwrite;
      wr_ofs  <= a_ofs;
      if (addr_ok && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      base_addr <= 24'h000000;
      blk_sel   <= 3'h0;
      ver_len   <= 16'h0001;
      wen       <= 1'b0;
    end else if (wr_pend) begin
      if (wr_ofs == OFS_ADDR) base_addr <= hwdata[23:0];
      if (wr_ofs == OFS_BLOCK) blk_sel <= hwdata[2:0];
      if (wr_ofs == OFS_LEN && hwdata[15:0] != 16'h0000) ver_len <= hwdata[15:0];
      if (wr_ofs == OFS_CMD) wen <= hwdata[C_WEN];
    end
  end

  always_ff @(posedge mclk) begin
    if (wr_pend && wr_ofs[7:5] == OFS_PBUF[7:5]) begin
      prog_buf[wr_ofs[4:2]] <= hwdata;
    end
  end

  // write enable is only raised on software request, so a runaway cannot reach the array
  assign flash_write_enable_pin = wen;

  // ****************************************************************
  // reset pin and error flag input
  // ****************************************************************
  logic [31:0] rst_cnt;
  logic [2:0]  err_sync;

  // power-on holds the pin for the oscillator time, a software pulse for 21 clocks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt     <= POR_CYC;
      reset_pin_n <= 1'b0;
    end else begin
      if (wr_cmd && hwdata[C_RST] && !busy) begin
        rst_cnt <= RST_MIN_CLK;
      end else if (rst_cnt != 32'h00000000) begin
        rst_cnt <= rst_cnt - 32'h00000001;
      end
      reset_pin_n <= (rst_cnt == 32'h00000000) && !(wr_cmd && hwdata[C_RST] && !busy);
    end
  end

  // the first stage feeds only the second; the flag changes once stages two and three agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_sync <= 3'b000;
      err_q    <= 1'b0;
    end else begin
      err_sync <= {err_sync[1:0], flash_error_flag};
      if (err_sync[2] == err_sync[1]) err_q <= err_sync[2];
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  logic        is_prog;
  logic        issued;
  logic [31:0] wcnt;
  logic [15:0] idx;
  logic [7:0]  ctl;
  logic        ver_bad;

  wire        su_bit   = is_prog ? ctl[B_PSU] : ctl[B_ESU];
  wire [2:0]  su_pos   = is_prog ? 3'(B_PSU) : 3'(B_ESU);
  wire [2:0]  md_pos   = is_prog ? 3'(B_PROG) : 3'(B_ERASE);
  wire [2:0]  vr_pos   = is_prog ? 3'(B_PVER) : 3'(B_EVER);
  wire        wait_end = issued && (wcnt == 32'h00000000);
  wire [4:0]  byte_i   = idx[4:0];
  wire [7:0]  load_b   = rep_buf[byte_i[4:2]][{byte_i[1:0], 3'b000} +: 8];
  wire [23:0] ver_addr = base_addr + {7'h00, idx, 1'b0};
  wire        last_ver = is_prog ? (idx == 16'(VER_WORDS - 1)) : (idx == ver_len - 16'h0001);
  wire        rep_done = &{rep_buf[0], rep_buf[1], rep_buf[2], rep_buf[3],
                           rep_buf[4], rep_buf[5], rep_buf[6], rep_buf[7]};
  wire        go       = wr_cmd && (state == ST_IDLE) && reset_pin_n;
  wire        go_e     = go && hwdata[C_ERASE];
  wire        go_p     = go && hwdata[C_PROG] && !hwdata[C_ERASE];
  wire        abort    = (state != ST_IDLE) && (!reset_pin_n || !wen);

  logic [7:0] next_ctl;
  always_comb begin
    next_ctl = ctl;
    case (state)
      ST_SWE:       next_ctl = 8'h01 << B_SWE;
      ST_SETUP:     next_ctl[su_pos] = 1'b1;
      ST_PULSE:     next_ctl[md_pos] = 1'b1;
      ST_PULSE_OFF: next_ctl[md_pos] = 1'b0;
      ST_SETUP_OFF: next_ctl[su_pos] = 1'b0;
      ST_VER_ON:    next_ctl[vr_pos] = 1'b1;
      ST_VER_OFF:   next_ctl[vr_pos] = 1'b0;
      ST_FINISH:    next_ctl = 8'h00;
      default:      next_ctl = ctl;
    endcase
  end

  // reprogram buffer: loaded from the originals, then refreshed from each verify word
  for (genvar w = 0; w < 8; w++) begin : g_rep
    wire hit = (state == ST_READ) && is_prog && issued && dev_rvalid && (idx[3:1] == w);
    always_ff @(posedge mclk) begin
      if (go_p) begin
        rep_buf[w] <= prog_buf[w];
      end else if (hit) begin
        rep_buf[w][{idx[0], 4'h0} +: 16] <= {
          prog_buf[w][{idx[0], 4'h8} +: 8] | ~dev_rdata[7:0],
          prog_buf[w][{idx[0], 4'h0} +: 8] | ~dev_rdata[15:8]};
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= ST_IDLE;
      is_prog <= 1'b0;
      issued  <= 1'b0;
      wcnt    <= 32'h00000000;
      idx     <= 16'h0000;
      ctl     <= 8'h00;
      ver_bad <= 1'b0;
      tries   <= 16'h0000;
      busy    <= 1'b0;
      done    <= 1'b0;
      fail    <= 1'b0;
      dev_req <= '0;
    end else begin
      dev_req.wr <= 1'b0;
      dev_req.rd <= 1'b0;
      if (issued && wcnt != 32'h00000000) wcnt <= wcnt - 32'h00000001;
      if (abort) begin
        // the device clears its registers on this same edge; our copy in ctl is cleared with them
        state  <= ST_IDLE;
        ctl    <= 8'h00;
        issued <= 1'b0;
        busy   <= 1'b0;
        fail   <= 1'b1;
        done   <= 1'b1;
      end else if (state == ST_IDLE) begin
        if (go_e || go_p) begin
          is_prog <= go_p;
          state   <= (wen && !err_q) ? ST_SWE : ST_IDLE;
          busy    <= wen && !err_q;
          done    <= !(wen && !err_q);
          fail    <= !(wen && !err_q);
          tries   <= 16'h0000;
          idx     <= 16'h0000;
        end
      end else if (!issued) begin
        issued       <= 1'b1;
        wcnt         <= 32'h00000000;
        dev_req.byte_acc <= 1'b0;
        if (state == ST_LOAD || state == ST_WDT || state == ST_DUMMY || state == ST_READ) begin
          dev_req.wr <= (state != ST_READ);
          dev_req.rd <= (state == ST_READ);
        end else begin
          ctl           <= next_ctl;
          dev_req.wr    <= 1'b1;
          dev_req.sel   <= DSEL_CTL;
          dev_req.wdata <= {8'h00, next_ctl};
        end
        case (state)
          ST_SWE:       wcnt <= X_CYC;
          ST_LOAD: begin
            dev_req.sel      <= is_prog ? DSEL_ARRAY : DSEL_BLK;
            dev_req.byte_acc <= is_prog;
            dev_req.addr     <= base_addr + {19'h00000, byte_i};
            dev_req.wdata    <= is_prog ? {8'h00, load_b} : {8'h00, 8'h01 << blk_sel};
          end
          ST_WDT: begin
            dev_req.sel   <= DSEL_WDT;
            dev_req.wdata <= WDT_VAL;
          end
          ST_SETUP:     wcnt <= Y_CYC;
          ST_PULSE:     wcnt <= is_prog ? ZP_CYC : ZE_CYC;
          ST_PULSE_OFF: wcnt <= ALPHA_CYC;
          ST_VER_ON:    wcnt <= GAMMA_CYC;
          ST_VER_OFF:   wcnt <= ETA_CYC;
          ST_DUMMY: begin
            dev_req.sel   <= DSEL_ARRAY;
            dev_req.addr  <= ver_addr;
            dev_req.wdata <= DUMMY_DATA;
            wcnt          <= EPS_CYC;
          end
          ST_READ: begin
            dev_req.sel  <= DSEL_ARRAY;
            dev_req.addr <= ver_addr;
          end
          default: wcnt <= 32'h00000000;
        endcase
        // with the flag set the device ignores the mode bit, so skip the pulse entirely
        if (state == ST_PULSE && err_q) begin
          dev_req.wr <= 1'b0;
          ctl        <= ctl;
          state      <= ST_PULSE_OFF;
          issued     <= 1'b0;
        end
      end else if (state == ST_READ) begin
        if (dev_rvalid) begin
          issued <= 1'b0;
          if (!is_prog && dev_rdata != ERASED_WORD) begin
            ver_bad <= 1'b1;
            state   <= ST_VER_OFF;
          end else if (last_ver) begin
            state <= ST_VER_OFF;
          end else begin
            idx   <= idx + 16'h0001;
            state <= ST_DUMMY;
          end
        end
      end else if (wait_end) begin
        issued <= 1'b0;
        case (state)
          ST_SWE: state <= ST_LOAD;
          ST_LOAD: begin
            idx   <= idx + 16'h0001;
            state <= (!is_prog || byte_i == 5'(PROG_BYTES - 1)) ? ST_WDT : ST_LOAD;
          end
          ST_WDT:       state <= ST_SETUP;
          ST_SETUP:     state <= ST_PULSE;
          ST_PULSE:     state <= ST_PULSE_OFF;
          ST_PULSE_OFF: state <= ST_SETUP_OFF;
          ST_SETUP_OFF: state <= err_q ? ST_FINISH : ST_VER_ON;
          ST_VER_ON: begin
            idx     <= 16'h0000;
            ver_bad <= 1'b0;
            state   <= ST_DUMMY;
          end
          ST_DUMMY: state <= ST_READ;
          ST_VER_OFF: begin
            idx <= 16'h0000;
            if ((is_prog ? rep_done : !ver_bad) || tries == 16'(N_MAX - 1)) begin
              fail  <= is_prog ? !rep_done : ver_bad;
              state <= ST_FINISH;
            end else begin
              tries <= tries + 16'h0001;
              state <= is_prog ? ST_LOAD : ST_WDT;
            end
          end
          ST_FINISH: begin
            fail  <= fail | err_q;
            busy  <= 1'b0;
            done  <= 1'b1;
            state <= ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

//--- verif/fpev_host_properties.sv
// assertion checker for the flash program/erase/verify host
`timescale 1ns/1ps
module fpev_host_properties
  import fpev_pkg::*;
#(
  parameter int unsigned X_CYC     = 3,
  parameter int unsigned Y_CYC     = 3,
  parameter int unsigned ZE_CYC    = 40,
  parameter int unsigned ALPHA_CYC = 3,
  parameter int unsigned GAMMA_CYC = 3,
  parameter int unsigned EPS_CYC   = 2
) (
  input wire logic          mclk,
  input wire logic          rst_n,
  input wire logic          hreadyout,
  input wire logic          hresp,
  input wire fpev_dev_req_s dev_req,
  input wire logic          reset_pin_n
);
  logic [7:0]  last_ctl;
  logic [31:0] since_ctl;
  logic [31:0] since_wr;
  logic [31:0] low_cnt;
  wire         ctl_wr = dev_req.wr && (dev_req.sel == DSEL_CTL);
  wire         arr_wr = dev_req.wr && (dev_req.sel == DSEL_ARRAY);
  wire         blk_wr = dev_req.wr && (dev_req.sel == DSEL_BLK);
  wire [7:0]   nc     = dev_req.wdata[7:0];
  // gaps are counted edge to edge from a device write to a later device write or read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_ctl  <= 8'h00;
      since_ctl <= 32'h0;
      since_wr  <= 32'h0;
      low_cnt   <= 32'h0;
    end else begin
      last_ctl  <= ctl_wr ? nc : last_ctl;
      since_ctl <= ctl_wr ? 32'h1 : since_ctl + 32'h1;
      since_wr  <= arr_wr ? 32'h1 : since_wr + 32'h1;
      low_cnt   <= reset_pin_n ? 32'h0 : low_cnt + 32'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_bus_ok;
    hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or not okay");
  property p_prog_exit;
    ctl_wr && last_ctl[B_PSU] && !nc[B_PSU] |-> !last_ctl[B_PROG] && since_ctl >= ALPHA_CYC;
  endproperty
  a_prog_exit: assert property (p_prog_exit) else $error("program setup cleared early");
  property p_erase_exit;
    ctl_wr && last_ctl[B_ESU] && !nc[B_ESU] |-> !last_ctl[B_ERASE] && since_ctl >= ALPHA_CYC;
  endproperty
  a_erase_exit: assert property (p_erase_exit) else $error("erase setup cleared early");
  property p_erase_on;
    ctl_wr && nc[B_ERASE] && !last_ctl[B_ERASE] |-> last_ctl[B_ESU] && since_ctl >= Y_CYC;
  endproperty
  a_erase_on: assert property (p_erase_on) else $error("erase bit set too soon");
  property p_erase_len;
    ctl_wr && last_ctl[B_ERASE] && !nc[B_ERASE] |-> since_ctl <= ZE_CYC + 2;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase pulse too long");
  property p_blk_after_swe;
    blk_wr && (nc != 8'h00) |-> last_ctl[B_SWE] && since_ctl >= X_CYC;
  endproperty
  a_blk_after_swe: assert property (p_blk_after_swe) else $error("block select too soon");
  property p_one_block;
    blk_wr |-> $onehot0(dev_req.wdata);
  endproperty
  a_one_block: assert property (p_one_block) else $error("several blocks selected");
  property p_dummy;
    arr_wr && (last_ctl[B_PVER] || last_ctl[B_EVER])
      |-> dev_req.wdata == DUMMY_DATA && since_ctl >= GAMMA_CYC;
  endproperty
  a_dummy: assert property (p_dummy) else $error("bad verify dummy write");
  property p_read_gap;
    dev_req.rd && dev_req.sel == DSEL_ARRAY |-> since_wr >= EPS_CYC ##1 !dev_req.rd;
  endproperty
  a_read_gap: assert property (p_read_gap) else $error("verify read too soon");
  property p_rst_len;
    $rose(reset_pin_n) |-> low_cnt >= RST_MIN_CLK;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("device reset too short");
  c_prog: cover property (ctl_wr && nc[B_PROG]);
  c_erase: cover property (ctl_wr && nc[B_ERASE]);
  c_rst: cover property ($rose(reset_pin_n));
endmodule

bind fpev_host fpev_host_properties #(.X_CYC(X_CYC), .Y_CYC(Y_CYC), .ZE_CYC(ZE_CYC),
  .ALPHA_CYC(ALPHA_CYC), .GAMMA_CYC(GAMMA_CYC), .EPS_CYC(EPS_CYC)) chk_u (
  .mclk(mclk), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp),
  .dev_req(dev_req), .reset_pin_n(reset_pin_n));

//--- verif/fpev_flash_model.sv
// behavioural flash device on the far side of the host's device port
`timescale 1ns/1ps
module fpev_flash_model
  import fpev_pkg::*;
(
  input  wire logic          mclk,
  input  wire fpev_dev_req_s dev_req,
  input  wire logic          flash_write_enable_pin,
  input  wire logic          reset_pin_n,
  output logic [15:0]        dev_rdata,
  output logic               dev_rvalid,
  output logic               flash_error_flag
);
  logic [7:0]  mem [0:255];
  logic [7:0]  pbuf [0:31];
  logic [7:0]  ctl;
  logic [7:0]  blk;
  logic [15:0] wdt;
  logic [7:0]  la;
  logic [2:0]  pbase;
  logic [15:0] rword;
  int          misses;
  int          lag_cyc;
  int          wait_n;
  logic        err_arm;
  wire [7:0]   nc  = dev_req.wdata[7:0];
  wire         ver = ctl[B_PVER] | ctl[B_EVER];
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    {ctl, blk, wdt, la, pbase, rword} = '0;
    misses = 0;
    lag_cyc = 0;
    wait_n = -1;
    err_arm = 1'b0;
    dev_rvalid = 1'b0;
    dev_rdata = 16'h0000;
    flash_error_flag = 1'b0;
  end
  // misses makes that many mode entries leave the array untouched
  always @(posedge mclk) begin
    dev_rvalid <= 1'b0;
    dev_rdata <= ~dev_rdata;
    if (wait_n == 0) begin
      dev_rvalid <= 1'b1;
      dev_rdata <= rword;
    end
    if (wait_n >= 0) wait_n = wait_n - 1;
    if (!reset_pin_n || !flash_write_enable_pin) begin
      ctl <= 8'h00;
      blk <= 8'h00;
      wdt <= 16'h0000;
      if (!reset_pin_n) flash_error_flag <= 1'b0;
    end else if (dev_req.wr && dev_req.sel == DSEL_CTL) begin
      if (err_arm && (nc[B_PSU] || nc[B_ESU])) begin
        flash_error_flag <= 1'b1;
        err_arm = 1'b0;
      end
      if (nc[B_PROG] && !ctl[B_PROG] && !flash_error_flag) begin
        if (misses > 0) misses--;
        else for (int i = 0; i < 32; i++) mem[{pbase, i[4:0]}] &= pbuf[i];
      end
      if (nc[B_ERASE] && !ctl[B_ERASE] && !flash_error_flag) begin
        if (misses > 0) misses--;
        else foreach (mem[i]) if (blk[i/32]) mem[i] = 8'hff;
      end
      if ((ctl[B_PSU] && !nc[B_PSU]) || (ctl[B_ESU] && !nc[B_ESU])) wdt <= 16'h0000;
      ctl <= nc;
    end else if (dev_req.wr) begin
      if (dev_req.sel == DSEL_BLK) blk <= nc;
      else if (dev_req.sel == DSEL_WDT) wdt <= dev_req.wdata;
      else if (ver) la <= dev_req.addr[7:0];
      else begin
        pbuf[dev_req.addr[4:0]] <= nc;
        pbase <= dev_req.addr[7:5];
      end
    end
    // outside verify mode a read answers with junk, so the host never hangs
    if (dev_req.rd) begin
      rword = dev_req.byte_acc ? {8'h00, mem[la]} : {mem[la], mem[la + 8'h01]};
      if (!ver) rword = ~rword;
      wait_n = lag_cyc;
    end
  end
endmodule

//--- verif/tb.sv
// self-checking bench for the flash program/erase/verify host
`timescale 1ns/1ps
module tb;
  import fpev_pkg::*;
  logic          mclk;
  logic          rst_n;
  logic [31:0]   haddr;
  logic [1:0]    htrans;
  logic          hsel;
  logic [2:0]    hsize;
  logic          hwrite;
  logic [31:0]   hwdata;
  logic          hreadyout;
  logic [31:0]   hrdata;
  logic          hresp;
  fpev_dev_req_s dev_req;
  logic [15:0]   dev_rdata;
  logic          dev_rvalid;
  logic          flash_error_flag;
  logic          flash_write_enable_pin;
  logic          reset_pin_n;
  int            error_cnt;
  int            checks;
  int            i;

  // shortened waits keep the run short; the order of the steps is what is checked
  localparam int unsigned SH_N = 3, SH_X = 3, SH_Y = 4, SH_ZP = 6, SH_ZE = 40;
  localparam int unsigned SH_A = 3, SH_G = 4, SH_E = 2, SH_H = 2, SH_POR = 30;

  fpev_host #(.N_MAX(SH_N), .X_CYC(SH_X), .Y_CYC(SH_Y), .ZP_CYC(SH_ZP), .ZE_CYC(SH_ZE),
    .ALPHA_CYC(SH_A), .GAMMA_CYC(SH_G), .EPS_CYC(SH_E), .ETA_CYC(SH_H), .POR_CYC(SH_POR)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .dev_req(dev_req),
    .dev_rdata(dev_rdata), .dev_rvalid(dev_rvalid), .flash_error_flag(flash_error_flag),
    .flash_write_enable_pin(flash_write_enable_pin), .reset_pin_n(reset_pin_n));
  fpev_flash_model fm_u (.mclk(mclk), .dev_req(dev_req),
    .flash_write_enable_pin(flash_write_enable_pin), .reset_pin_n(reset_pin_n),
    .dev_rdata(dev_rdata), .dev_rvalid(dev_rvalid), .flash_error_flag(flash_error_flag));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    hsize <= 3'h2;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  // polls the done flag, which accepting a start clears, so a finished earlier run cannot fool it
  task automatic wait_done();
    logic [31:0] q;
    q = 32'h0;
    for (int n = 0; n < 3000 && q[1] !== 1'b1; n++) bus(1'b0, OFS_STATUS, 32'h0, q);
  endtask
  function automatic logic [7:0] pb(input int n);
    return n[7:0] ^ 8'h3c;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    error_cnt++;
    tally_and_finish();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    error_cnt = 0;
    checks = 0;
    rst_n = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hsel = 1'b0;
    hsize = 3'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (40) @(posedge mclk);
    rd(OFS_LEN, 32'h1);
    rd(8'hf0, 32'h0);
    rd(OFS_STATUS, 32'h0);
    $display("reset test done");
    wr(OFS_CMD, 32'h2);
    wait_done();
    rd(OFS_STATUS, 32'h6);
    $display("refused start test done");
    wr(OFS_ADDR, 32'h20);
    for (i = 0; i < 8; i++) wr(OFS_PBUF + 8'(4 * i), {pb(4*i+3), pb(4*i+2), pb(4*i+1), pb(4*i)});
    fm_u.misses = 1;
    wr(OFS_CMD, 32'h8);
    @(posedge mclk);
    chk({31'h0, flash_write_enable_pin}, 32'h1);
    wr(OFS_CMD, 32'ha);
    wait_done();
    rd(OFS_STATUS, 32'h0001_0002);
    for (i = 0; i < 32; i++) chk({24'h0, fm_u.mem[32 + i]}, {24'h0, pb(i)});
    for (i = 0; i < 8; i++) rd(OFS_RBUF + 8'(4 * i), 32'hffff_ffff);
    $display("program retry test done");
    wr(OFS_ADDR, 32'h40);
    fm_u.misses = 10;
    wr(OFS_CMD, 32'ha);
    wait_done();
    rd(OFS_STATUS, 32'h6, 32'h7);
    $display("retry limit test done");
    fm_u.misses = 1;
    fm_u.lag_cyc = 5;
    wr(OFS_BLOCK, 32'h1);
    wr(OFS_LEN, 32'h10);
    wr(OFS_ADDR, 32'h20);
    wr(OFS_CMD, 32'h9);
    wait_done();
    rd(OFS_STATUS, 32'h0001_0002);
    for (i = 0; i < 32; i++) chk({24'h0, fm_u.mem[32 + i]}, 32'hff);
    $display("erase retry test done");
    fm_u.err_arm = 1'b1;
    wr(OFS_CMD, 32'h9);
    wait_done();
    rd(OFS_STATUS, 32'he, 32'hf);
    wr(OFS_CMD, 32'hc);
    repeat (100) @(posedge mclk);
    rd(OFS_STATUS, 32'h0, 32'h8);
    $display("error flag test done");
    wr(OFS_CMD, 32'ha);
    wr(OFS_CMD, 32'h0);
    wait_done();
    rd(OFS_STATUS, 32'h6, 32'h7);
    chk({24'h0, fm_u.ctl}, 32'h0);
    chk({31'h0, flash_write_enable_pin}, 32'h0);
    $display("write enable drop test done");
    tally_and_finish();
  end
endmodule
